// ### sim/pomc_media_src.sv
// media sensing source feeding the sensed-media input
module pomc_media_src (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] pick,
    output logic      [7:0] amsMedia
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************
    // sensed media, 2 bits per port
    // ****************
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            amsMedia <= 8'h00;
        end else begin
            amsMedia <= pick;
        end
    end
endmodule : pomc_media_src

// ### sim/tb_top.sv
// self-checking bench for the operating mode configuration block
`include "pomc_defs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pomc_pkg::*;
    // ****************
    // signals
    // ****************
    logic             core_clk  = 1'b0;
    logic             rst_n     = 1'b0;
    logic [6:0]       regAddr   = 7'h00;
    logic [15:0]      regWrData = 16'h0000;
    logic             regWr     = 1'b0;
    logic             regRd     = 1'b0;
    logic [7:0]       pick      = 8'h00;
    logic [7:0]       amsMedia;
    logic [15:0]      regRdData;
    pomc_port_t [3:0] portCfg;
    pomc_media_e [3:0] portMedia;
    logic [3:0]       amsEnable;
    logic [3:0]       portInUse;
    logic [3:0]       gigOnly;
    logic [3:0]       resetBusy;
    logic [3:0]       sdCmdMask;
    logic [1:0]       macIfMode;
    logic             sdCmdStrobe;
    pomc_cmd_e        sdCmdKind;
    logic [15:0]      sdCmdWord;
    logic [15:0]      rdv;
    logic [31:0]      seed = 32'hefe6;
    logic [4:0]       expMode [4];
    logic [3:0]       expMedAn;
    logic [3:0]       expMacAn;
    logic [1:0]       expG;
    int               failures = 0;
    int               testsRun = 0;
    int               cycles = 0;
    localparam logic [15:0] CW [6] = '{16'h80f0, 16'h80e0, 16'h8fc1, 16'h8fd1, 16'h83c1, 16'h1234};
    localparam pomc_cmd_e   CK [6] = '{CMD_MAC_SGX, CMD_MAC_QSG, CMD_MED_X, CMD_MED_FX, CMD_MED_X, CMD_OTHER};
    always #25 core_clk = ~core_clk;
    pomc_top uut (
        .core_clk, .rst_n, .regAddr, .regWrData, .regWr, .regRd, .amsMedia, .regRdData, .portCfg,
        .portMedia, .amsEnable, .macIfMode, .portInUse, .gigOnly, .resetBusy, .sdCmdStrobe,
        .sdCmdKind, .sdCmdMask, .sdCmdWord
    );
    pomc_media_src src (.core_clk, .rst_n, .pick, .amsMedia);
    // ****************
    // helpers
    // ****************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [2:0] dec(input logic [2:0] m);
        return (m > 3'h3) ? `POMC_MED_OTHER : m;
    endfunction : dec
    task automatic print_verdict();
        if (failures == 0 && testsRun > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        testsRun++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [1:0] p, input logic [4:0] r, input logic [15:0] d);
        @(posedge core_clk);
        regAddr   <= {p, r};
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge core_clk);
        regWr     <= 1'b0;
    endtask : wr
    task automatic rd(input logic [1:0] p, input logic [4:0] r);
        @(posedge core_clk);
        regAddr <= {p, r};
        regRd   <= 1'b1;
        @(posedge core_clk);
        regRd   <= 1'b0;
        #1 rdv = regRdData;
    endtask : rd
    task automatic srst(input logic [1:0] p, input logic an);
        int n;
        n = 0;
        wr(p, `POMC_REG_CTRL, {3'h4, an, 12'h000});
        rd(p, `POMC_REG_CTRL);
        chk(rdv[15], 1'b1);
        while (resetBusy !== 4'h0 && n < 20) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk(16'(n < 20), 16'h0001);
        repeat (2) @(posedge core_clk);
        #1;
        rd(p, `POMC_REG_CTRL);
        chk(rdv, {3'h0, an, 12'h000});
    endtask : srst
    task automatic chkAll();
        for (int q = 0; q < 4; q++) begin
            chk(portCfg[q].mode, expMode[q]);
            chk(portCfg[q].mediaAn, expMedAn[q]);
            chk(portCfg[q].macAn, expMacAn[q]);
            chk(portMedia[q], dec(expMode[q][2:0]));
            chk(amsEnable[q], expMode[q][2]);
            chk(gigOnly[q], expMode[q][4]);
        end
        chk(macIfMode, expG);
        chk(portInUse, (expG == 2'h1) ? 4'h1 : 4'hf);
    endtask : chkAll
    // ****************
    // watchdog
    // ****************
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            print_verdict();
        end
    end
    // ****************
    // main sequence
    // ****************
    initial begin
        int p;
        logic [4:0] m;
        expMode  = '{default: 5'h00};
        expMedAn = 4'h0;
        expMacAn = 4'h0;
        expG     = 2'h0;
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        #1 chkAll();
        rd(2'h0, 5'h05);
        chk(rdv, 16'h0000);
        for (int i = 0; i < 12; i++) begin
            seed = xs(seed);
            p = int'(seed[1:0]);
            m = {seed[9:8], (i >= 8) & seed[10], 2'(i)};
            if (m[2:0] == 3'h1) m[3] = 1'b0;
            wr(p[1:0], `POMC_REG_MODE, {3'h0, m, 8'h00});
            rd(p[1:0], `POMC_REG_MODE);
            chk(rdv, {3'h0, expMode[p], 8'h00});
            chkAll();
            expMode[p]  = m;
            expMedAn[p] = (m[2:0] != 3'h3);
            srst(p[1:0], expMedAn[p]);
            chkAll();
            rd(p[1:0], `POMC_REG_MODE);
            chk(rdv, {3'h0, m, 8'h00});
            seed = xs(seed);
            wr(p[1:0], `POMC_REG_MACAN, {8'h00, seed[3], 7'h00});
            expMacAn[p] = seed[3];
            pick <= seed[15:8];
            rd(p[1:0], `POMC_REG_AMSST);
            chk(rdv, {8'h00, pick[2*p +: 2], 6'h00});
            chkAll();
        end
        wr(2'h0, `POMC_REG_GMODE, 16'h4000);
        rd(2'h3, `POMC_REG_GMODE);
        chk(rdv, 16'h4000);
        chkAll();
        expG = 2'h1;
        srst(2'h2, expMedAn[2]);
        chkAll();
        wr(2'h0, `POMC_REG_GMODE, 16'h0000);
        expG = 2'h0;
        srst(2'h1, expMedAn[1]);
        chkAll();
        wr(2'h0, `POMC_REG_BCAST, 16'h0001);
        wr(2'h1, `POMC_REG_MODE, 16'h1a00);
        wr(2'h2, `POMC_REG_MACAN, 16'h0080);
        expMode  = '{default: 5'h1a};
        expMedAn = 4'hf;
        expMacAn = 4'hf;
        srst(2'h1, 1'b1);
        chkAll();
        wr(2'h0, `POMC_REG_BCAST, 16'h0000);
        for (int k = 0; k < 6; k++) begin
            wr(2'h0, `POMC_REG_SDCMD, CW[k]);
            #1 chk(sdCmdStrobe, 1'b1);
            chk(sdCmdKind, CK[k]);
            chk(sdCmdMask, (CK[k] == CMD_MED_X || CK[k] == CMD_MED_FX) ? CW[k][11:8] : 4'h0);
            chk(sdCmdWord, CW[k]);
            @(posedge core_clk);
            #1 chk(sdCmdStrobe, 1'b0);
        end
        rd(2'h2, `POMC_REG_SDCMD);
        chk(rdv, CW[5]);
        print_verdict();
    end
endmodule : tb_top

// ### src/pomc_defs.svh
// constants for the operating mode configuration block
`ifndef POMC_DEFS_SVH
`define POMC_DEFS_SVH
// ****************************************
// addressing: [6:5] port, [4:0] register
// ****************************************
`define POMC_AW          7
`define POMC_DW          16
`define POMC_NPORT       4
`define POMC_REG_CTRL    5'h00
`define POMC_REG_MACAN   5'h10
`define POMC_REG_SDCMD   5'h12
`define POMC_REG_GMODE   5'h13
`define POMC_REG_AMSST   5'h14
`define POMC_REG_BCAST   5'h16
`define POMC_REG_MODE    5'h17
// ****************************************
// field positions
// ****************************************
`define POMC_CTRL_SRST   15
`define POMC_CTRL_MAN    12
`define POMC_MODE_MSB    12
`define POMC_MODE_LSB    8
`define POMC_MODE_AMS    10
`define POMC_MACAN_BIT   7
`define POMC_AMSST_MSB   7
`define POMC_AMSST_LSB   6
`define POMC_GMODE_MSB   15
`define POMC_GMODE_LSB   14
`define POMC_BCAST_BIT   0
`define POMC_MASK_MSB    11
`define POMC_MASK_LSB    8
// ****************************************
// encodings and reset values
// ****************************************
`define POMC_GMODE_SGMII  2'h0
`define POMC_GMODE_QSGMII 2'h1
`define POMC_MED_CU       3'h0
`define POMC_MED_CUSFP    3'h1
`define POMC_MED_X1000    3'h2
`define POMC_MED_FX100    3'h3
`define POMC_MED_OTHER    3'h4
`define POMC_CMD_MAC_SGX  16'h80f0
`define POMC_CMD_MAC_QSG  16'h80e0
`define POMC_CMD_MED_X    16'h80c1
`define POMC_CMD_MED_FX   16'h80d1
`define POMC_MODE_RST     5'h00
`define POMC_GMODE_RST    2'h0
// ****************************************
// timing
// ****************************************
`define POMC_CLK_NS      50
`define POMC_SRST_NS     200
`define POMC_SRST_CYC    ((`POMC_SRST_NS + `POMC_CLK_NS - 1) / `POMC_CLK_NS)
`endif

// ### src/pomc_pkg.sv
// types for the operating mode configuration block
`include "pomc_defs.svh"
package pomc_pkg;
    typedef struct packed {
        logic       macProto;
        logic       amsPref;
        logic [2:0] media;
    } pomc_mode_t;
    typedef struct packed {
        pomc_mode_t mode;
        logic       mediaAn;
        logic       macAn;
    } pomc_port_t;
    typedef enum logic [2:0] {
        MED_CU    = `POMC_MED_CU,
        MED_CUSFP = `POMC_MED_CUSFP,
        MED_X1000 = `POMC_MED_X1000,
        MED_FX100 = `POMC_MED_FX100,
        MED_OTHER = `POMC_MED_OTHER
    } pomc_media_e;
    typedef enum logic [2:0] {
        CMD_NONE, CMD_MAC_SGX, CMD_MAC_QSG, CMD_MED_X, CMD_MED_FX, CMD_OTHER
    } pomc_cmd_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_BUSY = 2'h1,
        ST_LOAD = 2'h3
    } pomc_rst_state_e;
endpackage : pomc_pkg

// ### src/pomc_port_cfg.sv
// one port: pending and active mode, software reset sequence
`include "pomc_defs.svh"
module pomc_port_cfg (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic                wrCtrl,
    input  wire logic                wrMode,
    input  wire logic                wrMacAn,
    input  wire logic [15:0]         wrData,
    output pomc_pkg::pomc_port_t     activeCfg,
    output pomc_pkg::pomc_mode_t     pendMode,
    output logic                     busy,
    output logic                     loaded
);
    import pomc_pkg::*;
    localparam logic [2:0] SRST_LAST = 3'(`POMC_SRST_CYC - 1);
    pomc_rst_state_e stateReg, stateNext;
    logic [2:0]      cntReg, cntNext;
    pomc_port_t      activeReg, activeNext;
    pomc_mode_t      pendReg, pendNext;
    logic            busyReg, busyNext;
    logic            loadedReg, loadedNext;
    logic            srstReq;

    assign srstReq = wrCtrl && wrData[`POMC_CTRL_SRST];

    always_comb begin
        stateNext  = stateReg;
        cntNext    = cntReg;
        activeNext = activeReg;
        pendNext   = pendReg;
        loadedNext = 1'b0;
        if (wrMode) begin
            pendNext = pomc_mode_t'(wrData[`POMC_MODE_MSB:`POMC_MODE_LSB]);
        end
        if (wrCtrl) begin
            activeNext.mediaAn = wrData[`POMC_CTRL_MAN];
        end
        if (wrMacAn) begin
            activeNext.macAn = wrData[`POMC_MACAN_BIT];
        end
        unique case (stateReg)
            ST_IDLE: begin
                if (srstReq) begin
                    stateNext = ST_BUSY;
                    cntNext   = SRST_LAST;
                end
            end
            ST_BUSY: begin
                if (cntReg == 3'h0) begin
                    stateNext = ST_LOAD;
                end else begin
                    cntNext = cntReg - 3'h1;
                end
            end
            ST_LOAD: begin
                activeNext.mode = pendReg;
                loadedNext      = 1'b1;
                stateNext       = ST_IDLE;
            end
            default: begin
                stateNext = ST_IDLE;
            end
        endcase
        busyNext = (stateNext != ST_IDLE);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            stateReg  <= ST_IDLE;
            cntReg    <= 3'h0;
            activeReg <= '0;
            pendReg   <= `POMC_MODE_RST;
            busyReg   <= 1'b0;
            loadedReg <= 1'b0;
        end else begin
            stateReg  <= stateNext;
            cntReg    <= cntNext;
            activeReg <= activeNext;
            pendReg   <= pendNext;
            busyReg   <= busyNext;
            loadedReg <= loadedNext;
        end
    end

    assign activeCfg = activeReg;
    assign pendMode  = pendReg;
    assign busy      = busyReg;
    assign loaded    = loadedReg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_req;
        srstReq && stateReg == ST_IDLE;
    endsequence
    sequence s_done;
        busyReg [*5] ##1 (loadedReg && !busyReg);
    endsequence
    AST_SRST_SEQ: assert property (s_req |=> s_done)
        else $error("software reset sequence wrong length");
    AST_MODE_HOLD: assert property ($changed(activeReg.mode) |-> loadedReg)
        else $error("active mode changed without software reset");
    AST_LOAD_VALUE: assert property (loadedReg |-> activeReg.mode == $past(pendReg))
        else $error("loaded mode differs from pending");
    AST_MACAN: assert property (wrMacAn |=> activeReg.macAn == $past(wrData[`POMC_MACAN_BIT]))
        else $error("mac autoneg enable not stored");
endmodule : pomc_port_cfg

// ### src/pomc_serdes_cmd.sv
// serdes configuration command capture and decode
`include "pomc_defs.svh"
module pomc_serdes_cmd (
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    input  wire logic                wr,
    input  wire logic [15:0]         wrData,
    output logic                     strobe,
    output pomc_pkg::pomc_cmd_e      kind,
    output logic [3:0]               mask,
    output logic [15:0]              word
);
    import pomc_pkg::*;
    localparam logic [15:0] MASK_BITS = 16'h0f00;
    logic       strobeReg, strobeNext;
    pomc_cmd_e  kindReg, kindNext;
    logic [3:0] maskReg, maskNext;
    logic [15:0] wordReg, wordNext;

    function automatic pomc_cmd_e classify(input logic [15:0] w);
        if (w == `POMC_CMD_MAC_SGX) begin
            classify = CMD_MAC_SGX;
        end else if (w == `POMC_CMD_MAC_QSG) begin
            classify = CMD_MAC_QSG;
        end else if ((w & ~MASK_BITS) == `POMC_CMD_MED_X) begin
            classify = CMD_MED_X;
        end else if ((w & ~MASK_BITS) == `POMC_CMD_MED_FX) begin
            classify = CMD_MED_FX;
        end else begin
            classify = CMD_OTHER;
        end
    endfunction : classify

    always_comb begin
        strobeNext = wr;
        kindNext   = kindReg;
        maskNext   = maskReg;
        wordNext   = wordReg;
        if (wr) begin
            wordNext = wrData;
            kindNext = classify(wrData);
            if (kindNext == CMD_MED_X || kindNext == CMD_MED_FX) begin
                maskNext = wrData[`POMC_MASK_MSB:`POMC_MASK_LSB];
            end else begin
                maskNext = 4'h0;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            strobeReg <= 1'b0;
            kindReg   <= CMD_NONE;
            maskReg   <= 4'h0;
            wordReg   <= 16'h0000;
        end else begin
            strobeReg <= strobeNext;
            kindReg   <= kindNext;
            maskReg   <= maskNext;
            wordReg   <= wordNext;
        end
    end

    assign strobe = strobeReg;
    assign kind   = kindReg;
    assign mask   = maskReg;
    assign word   = wordReg;

    AST_CMD_MASK: assert property (@(posedge core_clk) disable iff (!rst_n)
        (wr && (wrData & ~MASK_BITS) == `POMC_CMD_MED_X)
        |=> strobeReg && kindReg == CMD_MED_X && maskReg == $past(wrData[11:8]))
        else $error("media command port mask wrong");
endmodule : pomc_serdes_cmd

// ### src/pomc_top.sv
// operating mode configuration: register port, global and per-port modes
// ****************************************
// ****************************************
//
// The address map and the strobed register port were decided locally.
`include "pomc_defs.svh"
module pomc_top (
    input  wire logic                           core_clk,
    input  wire logic                           rst_n,
    input  wire logic [`POMC_AW-1:0]            regAddr,
    input  wire logic [15:0]                    regWrData,
    input  wire logic                           regWr,
    input  wire logic                           regRd,
    input  wire logic [7:0]                     amsMedia,
    output logic [15:0]                         regRdData,
    output pomc_pkg::pomc_port_t [3:0]          portCfg,
    output pomc_pkg::pomc_media_e [3:0]         portMedia,
    output logic [3:0]                          amsEnable,
    output logic [1:0]                          macIfMode,
    output logic [3:0]                          portInUse,
    output logic [3:0]                          gigOnly,
    output logic [3:0]                          resetBusy,
    output logic                                sdCmdStrobe,
    output pomc_pkg::pomc_cmd_e                 sdCmdKind,
    output logic [3:0]                          sdCmdMask,
    output logic [15:0]                         sdCmdWord
);
    import pomc_pkg::*;

    // ****************************************
    // decode
    // ****************************************
    logic [4:0]       regSel;
    logic [1:0]       portSel;
    logic [3:0]       wrCtrl;
    logic [3:0]       wrMode;
    logic [3:0]       wrMacAn;
    logic             wrSdCmd;
    pomc_port_t [3:0] activeCfg;
    pomc_mode_t [3:0] pendMode;
    logic [3:0]       busy;
    logic [3:0]       loaded;

    assign regSel  = regAddr[4:0];
    assign portSel = regAddr[6:5];
    assign wrSdCmd = regWr && regSel == `POMC_REG_SDCMD;

    function automatic logic portHit(input logic [1:0] sel, input logic bc, input int p);
        portHit = bc || sel == 2'(p);
    endfunction : portHit

    function automatic pomc_media_e mediaOf(input pomc_mode_t m);
        unique case (m.media)
            `POMC_MED_CU:    mediaOf = MED_CU;
            `POMC_MED_CUSFP: mediaOf = MED_CUSFP;
            `POMC_MED_X1000: mediaOf = MED_X1000;
            `POMC_MED_FX100: mediaOf = MED_FX100;
            default:         mediaOf = MED_OTHER;
        endcase
    endfunction : mediaOf

    // ****************************************
    // global registers
    // ****************************************
    logic [1:0] gmodePendReg, gmodePendNext;
    logic [1:0] gmodeReg, gmodeNext;
    logic       bcastReg, bcastNext;
    logic [3:0] inUseReg, inUseNext;

    always_comb begin
        gmodePendNext = gmodePendReg;
        gmodeNext     = gmodeReg;
        bcastNext     = bcastReg;
        if (regWr && regSel == `POMC_REG_GMODE) begin
            gmodePendNext = regWrData[`POMC_GMODE_MSB:`POMC_GMODE_LSB];
        end
        if (regWr && regSel == `POMC_REG_BCAST) begin
            bcastNext = regWrData[`POMC_BCAST_BIT];
        end
        if (|loaded) begin
            gmodeNext = gmodePendReg;
        end
        if (gmodeNext == `POMC_GMODE_QSGMII) begin
            inUseNext = 4'h1;
        end else begin
            inUseNext = 4'hf;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            gmodePendReg <= `POMC_GMODE_RST;
            gmodeReg     <= `POMC_GMODE_RST;
            bcastReg     <= 1'b0;
            inUseReg     <= 4'hf;
        end else begin
            gmodePendReg <= gmodePendNext;
            gmodeReg     <= gmodeNext;
            bcastReg     <= bcastNext;
            inUseReg     <= inUseNext;
        end
    end

    assign macIfMode = gmodeReg;
    assign portInUse = inUseReg;

    // ****************************************
    // per-port configuration
    // ****************************************
    for (genvar p = 0; p < `POMC_NPORT; p++) begin : g_port
        assign wrCtrl[p]  = regWr && regSel == `POMC_REG_CTRL && portHit(portSel, bcastReg, p);
        assign wrMode[p]  = regWr && regSel == `POMC_REG_MODE && portHit(portSel, bcastReg, p);
        assign wrMacAn[p] = regWr && regSel == `POMC_REG_MACAN && portHit(portSel, bcastReg, p);
        pomc_port_cfg u_port (
            .core_clk  (core_clk),
            .rst_n     (rst_n),
            .wrCtrl    (wrCtrl[p]),
            .wrMode    (wrMode[p]),
            .wrMacAn   (wrMacAn[p]),
            .wrData    (regWrData),
            .activeCfg (activeCfg[p]),
            .pendMode  (pendMode[p]),
            .busy      (busy[p]),
            .loaded    (loaded[p])
        );
    end

    assign portCfg   = activeCfg;
    assign resetBusy = busy;

    // ****************************************
    // derived per-port state
    // ****************************************
    pomc_media_e [3:0] mediaReg, mediaNext;
    logic [3:0]        gigReg, gigNext;
    logic [3:0]        amsReg, amsNext;

    always_comb begin
        for (int p = 0; p < `POMC_NPORT; p++) begin
            mediaNext[p] = mediaOf(activeCfg[p].mode);
            gigNext[p]   = activeCfg[p].mode.macProto;
            amsNext[p]   = activeCfg[p].mode.media[2];
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mediaReg <= '{default: MED_CU};
            gigReg   <= 4'h0;
            amsReg   <= 4'h0;
        end else begin
            mediaReg <= mediaNext;
            gigReg   <= gigNext;
            amsReg   <= amsNext;
        end
    end

    assign portMedia = mediaReg;
    assign gigOnly   = gigReg;
    assign amsEnable = amsReg;

    // ****************************************
    // serdes command
    // ****************************************
    pomc_serdes_cmd u_cmd (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr       (wrSdCmd),
        .wrData   (regWrData),
        .strobe   (sdCmdStrobe),
        .kind     (sdCmdKind),
        .mask     (sdCmdMask),
        .word     (sdCmdWord)
    );

    // ****************************************
    // read port
    // ****************************************
    logic [15:0] rdReg, rdNext;
    pomc_port_t  rdPort;
    logic [1:0]  rdAms;

    always_comb begin
        rdPort = activeCfg[portSel];
        rdAms  = amsMedia[2*portSel +: 2];
        rdNext = 16'h0000;
        if (regRd) begin
            unique case (regSel)
                `POMC_REG_CTRL: begin
                    rdNext[`POMC_CTRL_SRST] = busy[portSel];
                    rdNext[`POMC_CTRL_MAN]  = rdPort.mediaAn;
                end
                `POMC_REG_MODE: begin
                    rdNext[`POMC_MODE_MSB:`POMC_MODE_LSB] = rdPort.mode;
                end
                `POMC_REG_MACAN: begin
                    rdNext[`POMC_MACAN_BIT] = rdPort.macAn;
                end
                `POMC_REG_AMSST: begin
                    rdNext[`POMC_AMSST_MSB:`POMC_AMSST_LSB] = rdAms;
                end
                `POMC_REG_GMODE: begin
                    rdNext[`POMC_GMODE_MSB:`POMC_GMODE_LSB] = gmodePendReg;
                end
                `POMC_REG_BCAST: begin
                    rdNext[`POMC_BCAST_BIT] = bcastReg;
                end
                `POMC_REG_SDCMD: begin
                    rdNext = sdCmdWord;
                end
                default: begin
                    rdNext = 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdReg <= 16'h0000;
        end else begin
            rdReg <= rdNext;
        end
    end

    assign regRdData = rdReg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    sequence s_bcast_mode;
        regWr && bcastReg && regSel == `POMC_REG_MODE;
    endsequence
    AST_BCAST: assert property (s_bcast_mode |=>
        pendMode[0] == $past(regWrData[12:8]) && pendMode[1] == pendMode[0]
        && pendMode[2] == pendMode[0] && pendMode[3] == pendMode[0])
        else $error("broadcast write missed a port");
    AST_RD_ACTIVE: assert property (regRd && regSel == `POMC_REG_MODE |=>
        regRdData[12:8] == $past(activeCfg[portSel].mode))
        else $error("mode read is not the active mode");
    AST_QSG_PORT0: assert property (macIfMode == `POMC_GMODE_QSGMII |-> portInUse == 4'h1)
        else $error("QSGMII uses a port other than 0");
    AST_GIG_ONLY: assert property (activeCfg[0].mode.macProto |=> gigOnly[0])
        else $error("1000BASE-X MAC port not limited to 1000 Mbps");
    AST_GMODE_LOAD: assert property (|loaded |=> macIfMode == $past(gmodePendReg))
        else $error("global MAC mode not loaded at reset");
    AST_RD_ONE: assert property (!regRd |=> regRdData == 16'h0000)
        else $error("read data outside the answer cycle");
endmodule : pomc_top
